/* File: inc/timer_pkg.sv */
package timer_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL_A     = 8'h5e;
    localparam logic [7:0] OFS_CONTROL_B     = 8'h5f;
    localparam logic [7:0] OFS_TOP_REQ_LO    = 8'h60;
    localparam logic [7:0] OFS_TOP_REQ_HI    = 8'h61;
    localparam logic [7:0] OFS_CMP_REQ_LO    = 8'h62;
    localparam logic [7:0] OFS_CMP_REQ_HI    = 8'h63;
    localparam logic [7:0] OFS_CONTROL_C     = 8'h64;
    localparam logic [7:0] OFS_COUNT_LO      = 8'h65;
    localparam logic [7:0] OFS_COUNT_HI      = 8'h66;
    localparam logic [7:0] OFS_ACT_TOP_LO    = 8'h67;
    localparam logic [7:0] OFS_ACT_TOP_HI    = 8'h68;
    localparam logic [7:0] OFS_ACT_CMP_LO    = 8'h69;
    localparam logic [7:0] OFS_ACT_CMP_HI    = 8'h6a;
    localparam logic [7:0] OFS_CAPTURE_LO    = 8'h6b;
    localparam logic [7:0] OFS_CAPTURE_HI    = 8'h6c;
    localparam logic [7:0] OFS_FLAGS         = 8'h6d;
    localparam logic [7:0] OFS_IRQ_PENDING   = 8'h6e;
    localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h6f;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_EXT_RESET_EN  = 7;
    localparam int BIT_DIV_SEL_LO    = 3;
    localparam int BIT_EDGE_SEL      = 2;
    localparam int BIT_SRC_SEL       = 1;
    localparam int BIT_SOVF_EN       = 6;
    localparam int BIT_CAPTURE_EN    = 5;
    localparam int BIT_TOP_SRC       = 4;
    localparam int BIT_OUT_MODE_LO   = 2;
    localparam int BIT_CNT_MODE_LO   = 0;
    localparam int BIT_FORCE         = 2;
    localparam int BIT_SOFT_RESET    = 1;
    localparam int BIT_PAUSE         = 0;
    localparam int BIT_BOTTOM        = 3;
    localparam int BIT_CAPTURE       = 2;
    localparam int BIT_COMPARE       = 1;
    localparam int BIT_OVERFLOW      = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_CONTROL  = 8'h00;
    localparam logic [15:0] RST_TOP      = 16'hffff;
    localparam logic [15:0] RST_COMPARE  = 16'hffff;
    localparam logic [15:0] RST_COUNT    = 16'h0000;
    localparam logic [15:0] RST_CAPTURE  = 16'h0000;
    localparam logic [3:0]  RST_FLAGS    = 4'h0;
    localparam logic [2:0]  RST_IRQ      = 3'h0;
    localparam logic [15:0] FIXED_TOP    = 16'hffff;

    // ----------------------------------------------------------------
    // divider terminal counts (divide by n -> n-1)
    // ----------------------------------------------------------------
    localparam logic [9:0] DIV_1_LAST    = 10'h000;
    localparam logic [9:0] DIV_8_LAST    = 10'h007;
    localparam logic [9:0] DIV_64_LAST   = 10'h03f;
    localparam logic [9:0] DIV_256_LAST  = 10'h0ff;
    localparam logic [9:0] DIV_1024_LAST = 10'h3ff;

    typedef enum logic [1:0] {
        MODE_WATCHDOG = 2'b00,
        MODE_CTC      = 2'b01,
        MODE_FAST_PWM = 2'b10,
        MODE_PFC_PWM  = 2'b11
    } counter_mode_e;

endpackage

/* File: hw/timer_capture_status_irq.sv */
`timescale 1ns/1ps
module timer_capture_status_irq
    import timer_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [7:0]  wb_dat_i,
    output logic      [7:0]  wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        capture_trigger_in,
    input  wire logic        counter_reset_in_n,
    output logic             timer_out,
    output logic             timer_irq
);
    import timer_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        ack;
        logic [7:0]  rdata;
        logic [7:0]  ctrl_a;
        logic [6:0]  ctrl_b;
        logic [2:0]  ctrl_c;
        logic [15:0] top_req;
        logic [15:0] cmp_req;
        logic [15:0] act_top;
        logic [15:0] act_cmp;
        logic [15:0] count;
        logic        count_down;
        logic [15:0] capture;
        logic [3:0]  flags;
        logic [2:0]  pending;
        logic [2:0]  irq_en;
        logic [9:0]  div_cnt;
        logic        trig_prev;
        logic        soft_rst_prev;
        logic        force_prev;
        logic        out_lvl;
        logic        irq;
    } state_s;

    localparam state_s STATE_RESET = '{
        ack:           1'b0,
        rdata:         8'h00,
        ctrl_a:        RST_CONTROL,
        ctrl_b:        RST_CONTROL[6:0],
        ctrl_c:        RST_CONTROL[2:0],
        top_req:       RST_TOP,
        cmp_req:       RST_COMPARE,
        act_top:       RST_TOP,
        act_cmp:       RST_COMPARE,
        count:         RST_COUNT,
        count_down:    1'b0,
        capture:       RST_CAPTURE,
        flags:         RST_FLAGS,
        pending:       RST_IRQ,
        irq_en:        RST_IRQ,
        div_cnt:       10'h000,
        trig_prev:     1'b0,
        soft_rst_prev: 1'b0,
        force_prev:    1'b0,
        out_lvl:       1'b0,
        irq:           1'b0
    };

    state_s state_r;
    state_s state_nxt;

    logic          access;
    logic          wr;
    logic [2:0]    div_sel;
    logic [9:0]    div_last;
    logic          tick;
    logic [15:0]   top_eff;
    counter_mode_e mode;
    logic [1:0]    out_mode;
    logic          soft_rst_rise;
    logic          force_rise;
    logic          ext_rst;
    logic          at_top;
    logic          at_cmp;
    logic          hit_zero;
    logic          cap_evt;
    logic [3:0]    flag_evt;
    logic [7:0]    rd_mux;
    logic          div_stop;
    logic          wr_flags;
    logic          wr_pending;

    // ----------------------------------------------------------------
    // combinational next state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt     = state_r;
        access        = wb_cyc_i && wb_stb_i && !state_r.ack;
        wr            = access && wb_we_i;
        wr_flags      = wr && (wb_adr_i == OFS_FLAGS);
        wr_pending    = wr && (wb_adr_i == OFS_IRQ_PENDING);
        div_sel       = state_r.ctrl_a[BIT_DIV_SEL_LO +: 3];
        mode          = counter_mode_e'(state_r.ctrl_b[BIT_CNT_MODE_LO +: 2]);
        out_mode      = state_r.ctrl_b[BIT_OUT_MODE_LO +: 2];
        top_eff       = state_r.ctrl_b[BIT_TOP_SRC] ? state_r.act_top : FIXED_TOP;
        soft_rst_rise = state_r.ctrl_c[BIT_SOFT_RESET] && !state_r.soft_rst_prev;
        force_rise    = state_r.ctrl_c[BIT_FORCE] && !state_r.force_prev;
        ext_rst       = state_r.ctrl_a[BIT_EXT_RESET_EN] && !counter_reset_in_n;
        at_top        = 1'b0;
        at_cmp        = 1'b0;
        hit_zero      = 1'b0;
        rd_mux        = 8'h00;

        // ------------------------------------------------------------
        // divider
        // ------------------------------------------------------------
        // reserved codes stop the clock like code zero; a guessed rate would hide misuse
        unique case (div_sel)
            3'h1:    div_last = DIV_1_LAST;
            3'h2:    div_last = DIV_8_LAST;
            3'h3:    div_last = DIV_64_LAST;
            3'h4:    div_last = DIV_256_LAST;
            3'h5:    div_last = DIV_1024_LAST;
            default: div_last = DIV_1_LAST;
        endcase
        tick     = 1'b0;
        div_stop = (div_sel == 3'h0) || (div_sel > 3'h5);
        if (div_stop)
        begin
            state_nxt.div_cnt = 10'h000;
        end
        else if (state_r.div_cnt >= div_last)
        begin
            state_nxt.div_cnt = 10'h000;
            tick              = 1'b1;
        end
        else
        begin
            state_nxt.div_cnt = state_r.div_cnt + 10'h001;
        end

        // ------------------------------------------------------------
        // counter
        // ------------------------------------------------------------
        state_nxt.soft_rst_prev = state_r.ctrl_c[BIT_SOFT_RESET];
        state_nxt.force_prev    = state_r.ctrl_c[BIT_FORCE];
        if (soft_rst_rise || ext_rst)
        begin
            // soft reset outranks pause
            state_nxt.count      = RST_COUNT;
            state_nxt.count_down = 1'b0;
        end
        else if (tick && !state_r.ctrl_c[BIT_PAUSE])
        begin
            at_top = (state_r.count == top_eff);
            at_cmp = (state_r.count == state_r.act_cmp);
            if (mode == MODE_PFC_PWM)
            begin
                if (at_top)
                begin
                    state_nxt.count_down = 1'b1;
                    state_nxt.count      = state_r.count - 16'h0001;
                end
                else if (state_r.count_down && state_r.count == 16'h0000)
                begin
                    // new values only at end of a full cycle
                    state_nxt.count_down = 1'b0;
                    state_nxt.count      = 16'h0001;
                    state_nxt.act_top    = state_r.top_req;
                    state_nxt.act_cmp    = state_r.cmp_req;
                end
                else if (state_r.count_down)
                begin
                    state_nxt.count = state_r.count - 16'h0001;
                end
                else
                begin
                    state_nxt.count = state_r.count + 16'h0001;
                end
            end
            else if (at_top || (mode == MODE_CTC && at_cmp))
            begin
                state_nxt.count   = RST_COUNT;
                state_nxt.act_top = state_r.top_req;
                state_nxt.act_cmp = state_r.cmp_req;
            end
            else
            begin
                state_nxt.count = state_r.count + 16'h0001;
            end
            hit_zero = (state_nxt.count == 16'h0000) && (state_r.count != 16'h0000);
        end

        // ------------------------------------------------------------
        // output waveform
        // ------------------------------------------------------------
        if (out_mode == 2'b00)
        begin
            state_nxt.out_lvl = 1'b0;
        end
        else if (mode == MODE_WATCHDOG || mode == MODE_CTC)
        begin
            if (out_mode == 2'b01 && (at_top || force_rise))
            begin
                state_nxt.out_lvl = !state_r.out_lvl;
            end
        end
        else if (mode == MODE_FAST_PWM)
        begin
            if (at_top)
            begin
                state_nxt.out_lvl = out_mode[0];
            end
            else if (at_cmp)
            begin
                state_nxt.out_lvl = !out_mode[0];
            end
        end
        else if (at_cmp)
        begin
            state_nxt.out_lvl = out_mode[0] ^ state_r.count_down;
        end

        // ------------------------------------------------------------
        // capture, trigger taken on its rising edge
        // ------------------------------------------------------------
        // edge, not level: a held trigger would keep rewriting the stamp
        state_nxt.trig_prev = capture_trigger_in;
        cap_evt = capture_trigger_in && !state_r.trig_prev && state_r.ctrl_b[BIT_CAPTURE_EN];
        if (cap_evt)
        begin
            state_nxt.capture = state_r.count;
        end

        // ------------------------------------------------------------
        // flags; set beats clear
        // ------------------------------------------------------------
        // compare, overflow and bottom events exist only on tick cycles; a paused counter still raises capture
        flag_evt = '0;
        flag_evt[BIT_BOTTOM]   = hit_zero;
        flag_evt[BIT_CAPTURE]  = cap_evt;
        flag_evt[BIT_COMPARE]  = at_cmp;
        flag_evt[BIT_OVERFLOW] = at_top;
        if (wr_flags)
        begin
            state_nxt.flags = flag_evt;
        end
        else
        begin
            state_nxt.flags = state_r.flags | flag_evt;
        end

        // ------------------------------------------------------------
        // interrupt pending and line
        // ------------------------------------------------------------
        // pending samples the registered flags, so w1c of a live enabled flag re-arms in the same cycle and never clears
        state_nxt.pending = state_r.pending;
        if (wr_pending)
        begin
            state_nxt.pending = state_r.pending & ~wb_dat_i[2:0];
        end
        state_nxt.pending = state_nxt.pending | (state_r.irq_en & state_r.flags[2:0]);

        // standalone mode bypasses pending; bottom never interrupts
        if (state_r.ctrl_b[BIT_SOVF_EN])
        begin
            state_nxt.irq = state_nxt.flags[BIT_OVERFLOW];
        end
        else
        begin
            state_nxt.irq = |state_nxt.pending;
        end

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wr)
        begin
            unique case (wb_adr_i)
                OFS_CONTROL_A:   state_nxt.ctrl_a = {wb_dat_i[7], 1'b0, wb_dat_i[5:1], 1'b0};
                OFS_CONTROL_B:   state_nxt.ctrl_b = wb_dat_i[6:0];
                OFS_CONTROL_C:   state_nxt.ctrl_c = wb_dat_i[2:0];
                OFS_TOP_REQ_LO:  state_nxt.top_req[7:0]  = wb_dat_i;
                OFS_TOP_REQ_HI:  state_nxt.top_req[15:8] = wb_dat_i;
                OFS_CMP_REQ_LO:  state_nxt.cmp_req[7:0]  = wb_dat_i;
                OFS_CMP_REQ_HI:  state_nxt.cmp_req[15:8] = wb_dat_i;
                OFS_IRQ_ENABLE:  state_nxt.irq_en = wb_dat_i[2:0];
                default:         ;
            endcase
        end

        // ------------------------------------------------------------
        // read mux; read-only bytes ignore writes above
        // ------------------------------------------------------------
        unique case (wb_adr_i)
            OFS_CONTROL_A:   rd_mux = state_r.ctrl_a;
            OFS_CONTROL_B:   rd_mux = {1'b0, state_r.ctrl_b};
            OFS_CONTROL_C:   rd_mux = {5'h00, state_r.ctrl_c};
            OFS_COUNT_LO:    rd_mux = state_r.count[7:0];
            OFS_COUNT_HI:    rd_mux = state_r.count[15:8];
            OFS_ACT_TOP_LO:  rd_mux = state_r.act_top[7:0];
            OFS_ACT_TOP_HI:  rd_mux = state_r.act_top[15:8];
            OFS_ACT_CMP_LO:  rd_mux = state_r.act_cmp[7:0];
            OFS_ACT_CMP_HI:  rd_mux = state_r.act_cmp[15:8];
            OFS_CAPTURE_LO:  rd_mux = state_r.capture[7:0];
            OFS_CAPTURE_HI:  rd_mux = state_r.capture[15:8];
            OFS_FLAGS:       rd_mux = {4'h0, state_r.flags};
            OFS_IRQ_PENDING: rd_mux = {5'h00, state_r.pending};
            OFS_IRQ_ENABLE:  rd_mux = {5'h00, state_r.irq_en};
            default:         rd_mux = 8'h00;
        endcase

        // ------------------------------------------------------------
        // bus answer
        // ------------------------------------------------------------
        // ack high blocks a second take of the same request
        state_nxt.ack = access;
        if (access)
        begin
            state_nxt.rdata = rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= STATE_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign wb_dat_o  = state_r.rdata;
    assign wb_ack_o  = state_r.ack;
    assign timer_out = state_r.out_lvl;
    assign timer_irq = state_r.irq;

endmodule

/* File: bench/timer_capture_status_irq_checker.sv */
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module timer_capture_status_irq_checker
    import timer_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic [7:0] wb_dat_o,
    input wire logic       wb_ack_o,
    input wire logic       capture_trigger_in,
    input wire logic       counter_reset_in_n,
    input wire logic       timer_out,
    input wire logic       timer_irq
);
    logic       taken;
    logic [2:0] en_r;
    logic [2:0] div_r;
    logic       sovf_r;
    logic       cap_en_r;
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // shadows of written controls; only bus writes can change them
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            en_r <= 3'h0;
            div_r <= 3'h0;
            sovf_r <= 1'b0;
            cap_en_r <= 1'b0;
        end
        else if (taken && wb_we_i)
        begin
            if (wb_adr_i == OFS_IRQ_ENABLE)
                en_r <= wb_dat_i[2:0];
            if (wb_adr_i == OFS_CONTROL_A)
                div_r <= wb_dat_i[5:3];
            if (wb_adr_i == OFS_CONTROL_B)
                sovf_r <= wb_dat_i[BIT_SOVF_EN];
            if (wb_adr_i == OFS_CONTROL_B)
                cap_en_r <= wb_dat_i[BIT_CAPTURE_EN];
        end
    end
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_ack_follows: assert property (taken |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_flags_upper: assert property (taken && !wb_we_i && wb_adr_i == OFS_FLAGS |=> wb_dat_o[7:4] == 4'h0)
        else $error("flags upper nibble not zero");
    a_ctrl_b_top: assert property (taken && !wb_we_i && wb_adr_i == OFS_CONTROL_B |=> !wb_dat_o[7])
        else $error("control b bit 7 not zero");
    a_ctrl_c_upper: assert property (taken && !wb_we_i && wb_adr_i == OFS_CONTROL_C |=> wb_dat_o[7:3] == 5'h00)
        else $error("control c upper bits not zero");
    a_irq_quiet: assert property (en_r == 3'h0 && !sovf_r && !$past(sovf_r) && !timer_irq |=> !timer_irq)
        else $error("irq rose with all enables clear");
    a_capture_irq: assert property ($rose(capture_trigger_in) && cap_en_r && en_r[2] && !sovf_r |-> ##2 timer_irq)
        else $error("capture did not raise irq");
    a_sovf_route: assert property (sovf_r && $past(sovf_r) && div_r == 3'h0 && $past(div_r) == 3'h0
        && !timer_irq |=> !timer_irq)
        else $error("standalone irq rose without overflow");
    c_write: cover property (taken && wb_we_i);
    c_capture: cover property ($rose(capture_trigger_in) && cap_en_r);
    c_irq: cover property ($rose(timer_irq));
endmodule
bind timer_capture_status_irq timer_capture_status_irq_checker chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .capture_trigger_in(capture_trigger_in),
    .counter_reset_in_n(counter_reset_in_n), .timer_out(timer_out), .timer_irq(timer_irq));

/* File: bench/wb_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// bus host model
// ----------------------------------------
module wb_host_model (
    input  wire logic       clk_sys,
    input  wire logic       ack,
    input  wire logic [7:0] dat_r,
    output logic            cyc,
    output logic            stb,
    output logic            we,
    output logic [7:0]      adr,
    output logic [7:0]      dat_w
);
    initial {cyc, stb, we, adr, dat_w} = 19'h00000;
    // request held until ack is seen high at a rising edge, for at most 8 rising edges
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
        int n;
        @(negedge clk_sys);
        {cyc, stb, we, adr, dat_w} = {1'b1, 1'b1, w, a, d};
        ok = 1'b0;
        for (n = 0; n < 8 && !ok; n++)
        begin
            @(posedge clk_sys);
            ok = (ack === 1'b1);
        end
        q = dat_r;
        @(negedge clk_sys);
        // released address and data lines show inverted values so stale ones cannot pass
        {cyc, stb, we, adr, dat_w} = {1'b0, 1'b0, 1'b0, ~a, ~d};
    endtask
endmodule

/* File: bench/timer_capture_status_irq_tb.sv */
`timescale 1ns/1ps
module timer_capture_status_irq_tb;
    import timer_pkg::*;
    // ----------------------------------------
    // bench signals and table
    // ----------------------------------------
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        trig = 1'b0;
    logic        cyc, stb, we, ack, irq, tout;
    logic [7:0]  adr, dat_w, dat_r, v_lo, v_hi;
    int          bad_count = 0;
    int          num_checks = 0;
    // address, write data, expected read back
    logic [23:0] rows [16] = '{24'h5effbe, 24'h5fff7f, 24'h64ff07, 24'h6fff07,
                               24'h603400, 24'h631200, 24'h665500, 24'h6baa00,
                               24'h6caa00, 24'h6800ff, 24'h6a00ff, 24'h705a00,
                               24'h5e0000, 24'h5f0000, 24'h640000, 24'h6f0000};
    always #20 clk_sys = ~clk_sys;
    wb_host_model host (.clk_sys(clk_sys), .ack(ack), .dat_r(dat_r), .cyc(cyc), .stb(stb), .we(we),
                        .adr(adr), .dat_w(dat_w));
    timer_capture_status_irq uut (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
                                  .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
                                  .wb_ack_o(ack), .capture_trigger_in(trig), .counter_reset_in_n(1'b1),
                                  .timer_out(tout), .timer_irq(irq));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        logic ok;
        host.xfer(w, a, d, q, ok);
        if (!ok)
        begin
            bad_count++;
            $display("mismatch ack expected 1 seen 0");
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        access(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        access(1'b0, a, 8'h00, q);
        check($sformatf("reg %h", a), e, q);
    endtask
    // one-cycle trigger, then one more cycle for the pending bit
    task automatic pulse();
        @(negedge clk_sys);
        trig = 1'b1;
        @(negedge clk_sys);
        trig = 1'b0;
        @(negedge clk_sys);
    endtask
    initial
    begin
        int n;
        repeat (2) @(negedge clk_sys);
        reset_n = 1'b1;
        for (n = 'h5e; n <= 'h6f; n++)
            rc(n[7:0], (n >= 'h67 && n <= 'h6a) ? 8'hff : 8'h00);
        for (n = 0; n < 16; n++)
        begin
            wr(rows[n][23:16], rows[n][15:8]);
            rc(rows[n][23:16], rows[n][7:0]);
        end
        // capture of a paused count, so both bytes are stable
        wr(8'h5f, 8'h20);
        wr(8'h6f, 8'h04);
        wr(8'h5e, 8'h08);
        repeat (40) @(negedge clk_sys);
        wr(8'h64, 8'h01);
        access(1'b0, 8'h65, 8'h00, v_lo);
        access(1'b0, 8'h66, 8'h00, v_hi);
        pulse();
        check("irq", 8'h01, {7'h00, irq});
        rc(8'h6b, v_lo);
        rc(8'h6c, v_hi);
        rc(8'h6d, 8'h04);
        rc(8'h6e, 8'h04);
        wr(8'h6e, 8'h04);
        rc(8'h6e, 8'h04);
        wr(8'h6d, 8'h00);
        rc(8'h6d, 8'h00);
        wr(8'h6e, 8'h03);
        rc(8'h6e, 8'h04);
        wr(8'h6e, 8'h04);
        rc(8'h6e, 8'h00);
        check("irq", 8'h00, {7'h00, irq});
        wr(8'h5f, 8'h00);
        pulse();
        rc(8'h6d, 8'h00);
        wr(8'h6f, 8'h00);
        wr(8'h5f, 8'h20);
        pulse();
        rc(8'h6d, 8'h04);
        rc(8'h6e, 8'h00);
        // standalone mode: capture still pends but the line stays low
        wr(8'h5e, 8'h00);
        wr(8'h5f, 8'h60);
        wr(8'h6f, 8'h07);
        pulse();
        rc(8'h6e, 8'h04);
        check("irq", 8'h00, {7'h00, irq});
        wr(8'h6d, 8'h00);
        wr(8'h6e, 8'h07);
        wr(8'h6f, 8'h00);
        wr(8'h5f, 8'h10);
        wr(8'h60, 8'h0f);
        wr(8'h61, 8'h00);
        wr(8'h62, 8'h05);
        wr(8'h63, 8'h00);
        wr(8'h64, 8'h02);
        wr(8'h5e, 8'h08);
        // new top only loads after a full pass at the old one
        v_lo = 8'hff;
        for (n = 0; n < 30000 && v_lo !== 8'h0f; n++)
            access(1'b0, 8'h67, 8'h00, v_lo);
        if (v_lo !== 8'h0f)
        begin
            bad_count++;
            $display("mismatch top load expected 0f seen %h", v_lo);
            complete_run();
        end
        rc(8'h67, 8'h0f);
        rc(8'h68, 8'h00);
        rc(8'h69, 8'h05);
        rc(8'h6a, 8'h00);
        rc(8'h6d, 8'h0b);
        wr(8'h6f, 8'h03);
        rc(8'h6e, 8'h03);
        check("irq", 8'h01, {7'h00, irq});
        // force edges toggle the output while paused, so no top match interferes
        wr(8'h64, 8'h01);
        wr(8'h5f, 8'h14);
        check("out", 8'h00, {7'h00, tout});
        wr(8'h64, 8'h05);
        check("out", 8'h01, {7'h00, tout});
        wr(8'h64, 8'h01);
        wr(8'h64, 8'h05);
        check("out", 8'h00, {7'h00, tout});
        // mid-run reset brings irq, out, flags, pending, active top and count back to their defaults
        @(negedge clk_sys);
        reset_n = 1'b0;
        @(negedge clk_sys);
        reset_n = 1'b1;
        check("irq", 8'h00, {7'h00, irq});
        check("out", 8'h00, {7'h00, tout});
        rc(8'h6d, 8'h00);
        rc(8'h6e, 8'h00);
        rc(8'h67, 8'hff);
        rc(8'h65, 8'h00);
        complete_run();
    end
endmodule
